// ===== mis_pkg.sv
// package for the interrupt sequencer: register map, fields, timing
package mis_pkg;
   // wishbone word offsets (byte addresses)
   localparam logic [7:0] ADDR_LATCH   = 8'h00;  // request latches, write 0 clears
   localparam logic [7:0] ADDR_ENABLE  = 8'h04;  // enable flags, bit 0 master
   localparam logic [7:0] ADDR_SELECT  = 8'h08;  // shared source selector
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;  // sequencer status (read only)
   localparam logic [7:0] ADDR_STACKP  = 8'h10;  // stack pointer
   localparam logic [7:0] ADDR_PSW     = 8'h14;  // program status word
   // field positions
   localparam int         BIT_MASTER   = 0;      // master enable in enable reg
   localparam int         BIT_SEL15    = 0;      // level-15 source select
   localparam int         BIT_SEL16    = 1;      // level-16 source select
   localparam int         LVL_15       = 14;     // latch index of level 15
   localparam int         LVL_16       = 15;     // latch index of level 16
   localparam int         NUM_LVL      = 16;     // latch vector width
   localparam int         FIRST_MASK   = 4;      // lowest maskable latch
   // reset values
   localparam logic [15:0] RST_LATCH   = 16'h0000;
   localparam logic [15:0] RST_ENABLE  = 16'h0000;
   localparam logic [7:0]  RST_SELECT  = 8'h00;
   localparam logic [7:0]  RST_SP      = 8'hFF;
   localparam logic [7:0]  RST_PSW     = 8'h00;
   // codes and timing
   localparam logic [7:0]  OP_SOFT_TRAP = 8'hFF; // also the open-bus value
   localparam int          ACCEPT_CYC   = 8;     // machine cycles to accept
   localparam int          STACK_BYTES  = 3;     // bytes pushed / popped
   localparam int          MAX_LAT_CYC  = 38;    // worst latch-to-accept
   localparam logic [7:0]  VEC_SOFT     = 8'hFE; // soft trap vector slot
   // stack access carrier
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } mis_stack_t;
endpackage : mis_pkg

// ===== mis_sequencer.sv
// interrupt latch, priority, acceptance and return sequencer
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module mis_sequencer (
   input  wire logic               clk_in,        // system clock
   input  wire logic               rst_n_in,      // sync reset, active low
   input  wire logic               ce_in,         // clock enable
   // wishbone slave
   input  wire logic               wb_cyc_in,
   input  wire logic               wb_stb_in,
   input  wire logic               wb_we_in,
   input  wire logic [7:0]         wb_adr_in,
   input  wire logic [3:0]         wb_sel_in,
   input  wire logic [31:0]        wb_dat_in,
   output logic      [31:0]        wb_dat_out,
   output logic                    wb_ack_out,
   // request sources (latch index 4 upward, one per latch to 13, two selectable per latch 14 and 15)
   input  wire logic [15:0]        src_req_in,    // plain level requests
   input  wire logic               ext_request_four_in,
   input  wire logic               serial_tx_request_in,
   input  wire logic               ext_request_five_in,
   input  wire logic               converter_done_request_in,
   // core side
   input  wire logic               instr_last_in, // last cycle of instruction
   input  wire logic               fetch_in,      // opcode fetch strobe
   input  wire logic [7:0]         fetch_data_in, // fetched opcode
   input  wire logic               fetch_absent_in, // nonexistent address
   input  wire logic               fetch_ram_in,  // fetch from ram or sfr
   input  wire logic               maskable_return_op_in,
   input  wire logic               nonmaskable_return_op_in,
   input  wire logic [15:0]        pc_in,         // current program counter
   input  wire logic [7:0]         stack_rd_in,   // stack read data
   input  wire logic [7:0]         vec_rd_in,     // vector table read data
   output logic                    busy_out,      // core stalled by sequence
   output logic                    pc_load_out,   // load pc
   output logic      [15:0]        pc_out,        // new pc value
   output mis_pkg::mis_stack_t     stack_out,     // stack access
   output logic      [7:0]         vec_adr_out,   // vector table address
   output logic                    trap_reset_out // address trap reset
);
   import mis_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   // idle, accepting an interrupt, or returning from one
   typedef enum {ST_IDLE, ST_ACC, ST_RET} mis_state_t;

   mis_state_t        state, next_state;          // sequencer phase
   logic [2:0]        cyc, next_cyc;              // machine cycle in phase
   logic [15:0]       latch, next_latch;          // request latches
   logic [15:0]       enable, next_enable;        // enable flags + master
   logic [7:0]        select, next_select;        // shared source selector
   logic [7:0]        sp, next_sp;                // stack pointer
   logic [7:0]        program_status_word, next_psw;              // status, bit 0 master
   logic [3:0]        acc_lvl, next_acc_lvl;      // level being accepted
   logic              acc_soft, next_acc_soft;    // soft trap accepted
   logic              soft_pend, next_soft_pend;  // soft trap raised
   logic [15:0]       pc_reg, next_pc_reg;        // pc output
   logic              pc_ld, next_pc_ld;          // pc load pulse
   mis_stack_t        stk, next_stk;              // stack access
   logic [7:0]        vadr, next_vadr;            // vector address
   logic              trst, next_trst;            // trap reset pulse
   logic [31:0]       rdat, next_rdat;            // bus read data
   logic              ack, next_ack;              // bus ack

   // combinational helpers
   // derived each cycle from the registers and inputs above
   logic [15:0]       set_vec;                    // latch set terms
   logic [15:0]       ready;                      // enabled pending latches
   logic              any_ready;
   logic [3:0]        top_lvl;
   logic              wr_go;
   logic [7:0]        op_now;                     // effective opcode
   logic              soft_hit;                   // soft trap code fetched

   ////////////////////////////////////////////////////////////////////////
   // latch set terms, one per level
   // a shared level listens only to the source the selector names;
   // the other source's requests are dropped, never held
   // levels below the first maskable one have no plain request
   genvar g;
   generate
      for (g = 0; g < NUM_LVL; g++) begin : g_set
         if (g == LVL_15) begin : g_l15
            assign set_vec[g] = select[BIT_SEL15] ?
                                serial_tx_request_in : ext_request_four_in;
         end else if (g == LVL_16) begin : g_l16
            assign set_vec[g] = select[BIT_SEL16] ?
                                converter_done_request_in :
                                ext_request_five_in;
         end else if (g >= FIRST_MASK) begin : g_pl
            assign set_vec[g] = src_req_in[g];
         end else begin : g_none
            assign set_vec[g] = 1'b0;
         end
      end
   endgenerate

   // pending and individually enabled, gated by master
   // a zero master flag hides every maskable latch
   assign ready = (enable[BIT_MASTER]) ?
                  (latch & enable & 16'hFFF0) : 16'h0000;
   assign any_ready = |ready;

   // highest priority = highest index
   // the last enabled level found in the scan wins
   always_comb begin
      top_lvl = 4'h0;
      for (int i = 0; i < NUM_LVL; i++) begin
         if (ready[i]) top_lvl = i[3:0];
      end
   end

   // open-bus fetch reads back as the soft trap code
   assign op_now = fetch_absent_in ? OP_SOFT_TRAP : fetch_data_in;
   // a ram or sfr fetch resets instead, so it never counts as a soft trap
   assign soft_hit = fetch_in & ~fetch_ram_in & (op_now == OP_SOFT_TRAP);
   assign wr_go  = wb_cyc_in & wb_stb_in & wb_we_in & ~ack;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   // every register keeps its value unless a branch below moves it, and the latches also take the set terms;
   // pulses (load, trap reset, ack, stack access) default to idle
   always_comb begin
      next_state    = state;
      next_cyc      = cyc;
      next_latch    = latch | set_vec;
      next_enable   = enable;
      next_select   = select;
      next_sp       = sp;
      next_psw      = program_status_word;
      next_acc_lvl  = acc_lvl;
      next_acc_soft = acc_soft;
      next_soft_pend = soft_pend;
      next_pc_reg   = pc_reg;
      next_pc_ld    = 1'b0;
      next_stk      = '0;
      next_vadr     = vadr;
      next_trst     = 1'b0;
      next_rdat     = rdat;
      next_ack      = 1'b0;
      // opcode fetch checks
      // the reset from a ram fetch outranks the soft trap
      if (fetch_in && fetch_ram_in) begin
         next_trst = 1'b1;
      end else if (soft_hit) begin
         next_soft_pend = 1'b1;
      end
      // bus access, one-cycle ack; write 0 clears latch, 1 leaves it
      // read data is registered with the ack; unmapped offsets read 0
      // a write lands at the edge that raises ack
      if (wb_cyc_in && wb_stb_in && !ack) begin
         next_ack = 1'b1;
         case (wb_adr_in)
            ADDR_LATCH:  next_rdat = {16'h0000, latch};
            ADDR_ENABLE: next_rdat = {16'h0000, enable};
            ADDR_SELECT: next_rdat = {24'h000000, select};
            ADDR_STATUS: next_rdat = {24'h000000, acc_soft, state != ST_IDLE,
                                      2'b00, acc_lvl};
            ADDR_STACKP: next_rdat = {24'h000000, sp};
            ADDR_PSW:    next_rdat = {24'h000000, program_status_word};
            default:     next_rdat = 32'h00000000;
         endcase
      end
      if (wr_go) begin
         case (wb_adr_in)
            ADDR_LATCH: begin
               if (wb_sel_in[0]) next_latch[7:0] =
                  (latch[7:0] & wb_dat_in[7:0]) | set_vec[7:0];
               if (wb_sel_in[1]) next_latch[15:8] =
                  (latch[15:8] & wb_dat_in[15:8]) | set_vec[15:8];
            end
            ADDR_ENABLE: begin
               if (wb_sel_in[0]) next_enable[7:0] = wb_dat_in[7:0];
               if (wb_sel_in[1]) next_enable[15:8] = wb_dat_in[15:8];
            end
            ADDR_SELECT: if (wb_sel_in[0]) next_select = wb_dat_in[7:0];
            ADDR_STACKP: if (wb_sel_in[0]) next_sp = wb_dat_in[7:0];
            ADDR_PSW:    if (wb_sel_in[0]) next_psw = wb_dat_in[7:0];
            default: ;
         endcase
      end
      // sequencer
      // a return op is taken at once; an acceptance waits for the
      // last cycle of the running instruction
      case (state)
         ST_IDLE: begin
            // a return has priority over an acceptance in one cycle
            if (maskable_return_op_in || nonmaskable_return_op_in) begin
               next_state = ST_RET;
               next_cyc   = 3'd0;
            end else if (instr_last_in &&
                         (next_soft_pend || soft_pend || any_ready)) begin
               next_state    = ST_ACC;
               next_cyc      = 3'd0;
               next_acc_soft = next_soft_pend | soft_pend;
               next_acc_lvl  = top_lvl;
            end
         end
         ST_ACC: begin                                 // 8 machine cycles
            next_cyc = cyc + 3'd1;
            // cycles 0-1 mask and clear, 2-4 push, 5-7 fetch the entry
            case (cyc)
               3'd0: begin
                  // status keeps old master; then master cleared
                  next_psw = {program_status_word[7:1], enable[BIT_MASTER]};
                  next_enable[BIT_MASTER] = 1'b0;
               end
               3'd1: begin
                  if (acc_soft) next_soft_pend = soft_hit;   // set wins
                  else next_latch[acc_lvl] = set_vec[acc_lvl];
               end
               3'd2: begin
                  next_stk = '{we: 1'b1, addr: sp, data: program_status_word};
                  next_sp  = sp - 8'd1;
               end
               3'd3: begin
                  next_stk = '{we: 1'b1, addr: sp, data: pc_in[15:8]};
                  next_sp  = sp - 8'd1;
               end
               3'd4: begin
                  next_stk = '{we: 1'b1, addr: sp, data: pc_in[7:0]};
                  next_sp  = sp - 8'd1;
                  next_vadr = acc_soft ? VEC_SOFT :
                              8'hFC - {3'b000, acc_lvl, 1'b0};
               end
               // table data trails its address by one cycle
               3'd5: begin
                  next_vadr = vadr + 8'd1;             // high byte slot
               end
               3'd6: next_pc_reg[7:0] = vec_rd_in;     // entry low byte
               default: begin                          // cycle 7
                  next_pc_reg[15:8] = vec_rd_in;
                  next_pc_ld = 1'b1;
                  next_state = ST_IDLE;
               end
            endcase
         end
         ST_RET: begin                                 // pop pc and status
            next_cyc = cyc + 3'd1;
            // stack data trails its read address by one cycle
            case (cyc)
               3'd0: next_stk = '{we: 1'b0, addr: sp + 8'd1, data: 8'h00};
               3'd1: next_stk = '{we: 1'b0, addr: sp + 8'd2, data: 8'h00};
               3'd2: begin
                  next_pc_reg[7:0] = stack_rd_in;
                  next_stk = '{we: 1'b0, addr: sp + 8'd3, data: 8'h00};
               end
               3'd3: next_pc_reg[15:8] = stack_rd_in;  // pc high byte
               default: begin                          // status word
                  next_psw = stack_rd_in;
                  next_enable[BIT_MASTER] = stack_rd_in[0];
                  next_sp = sp + 8'(STACK_BYTES);
                  next_pc_ld = 1'b1;
                  next_state = ST_IDLE;
               end
            endcase
         end
         default: next_state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   // one register stage; a low clock enable freezes all state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         cyc <= 3'd0;
         latch <= RST_LATCH;
         enable <= RST_ENABLE;
         select <= RST_SELECT;
         sp <= RST_SP;
         program_status_word <= RST_PSW;
         acc_lvl <= 4'h0;
         acc_soft <= 1'b0;
         soft_pend <= 1'b0;
         pc_reg <= 16'h0000;
         pc_ld <= 1'b0;
         stk <= '0;
         vadr <= 8'h00;
         trst <= 1'b0;
         rdat <= 32'h00000000;
         ack <= 1'b0;
      end else if (ce_in) begin
         state <= next_state;
         cyc <= next_cyc;
         latch <= next_latch;
         enable <= next_enable;
         select <= next_select;
         sp <= next_sp;
         program_status_word <= next_psw;
         acc_lvl <= next_acc_lvl;
         acc_soft <= next_acc_soft;
         soft_pend <= next_soft_pend;
         pc_reg <= next_pc_reg;
         pc_ld <= next_pc_ld;
         stk <= next_stk;
         vadr <= next_vadr;
         trst <= next_trst;
         rdat <= next_rdat;
         ack <= next_ack;
      end
   end

   // outputs
   // all outputs come straight from flops except busy
   assign wb_dat_out     = rdat;
   assign wb_ack_out     = ack;
   assign busy_out       = (state != ST_IDLE);
   assign pc_load_out    = pc_ld;
   assign pc_out         = pc_reg;
   assign stack_out      = stk;
   assign vec_adr_out    = vadr;
   assign trap_reset_out = trst;
endmodule : mis_sequencer

// ===== mis_seq_chk.sv
// port checker for the interrupt sequencer, bound to the sequencer module
`timescale 1ns/10ps
module mis_seq_chk
   import mis_pkg::*;
(
   input wire logic                clk_in,
   input wire logic                rst_n_in,
   input wire logic                ce_in,
   input wire logic                wb_cyc_in,
   input wire logic                wb_stb_in,
   input wire logic                wb_ack_out,
   input wire logic                instr_last_in,
   input wire logic                fetch_in,
   input wire logic                fetch_ram_in,
   input wire logic                maskable_return_op_in,
   input wire logic                nonmaskable_return_op_in,
   input wire logic [15:0]         pc_in,
   input wire logic                busy_out,
   input wire logic                pc_load_out,
   input wire mis_pkg::mis_stack_t stack_out,
   input wire logic                trap_reset_out
);
   ////////////////////////////////////////////////////////////////////////
   // one clock domain, reset disables every check
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // a start of busy that no return pulse caused is an acceptance
   a_bus_ack_next: assert property (wb_cyc_in && wb_stb_in && ce_in
      && !wb_ack_out |=> wb_ack_out) else $error("no ack after request");
   a_accept_eight_cycles: assert property ($rose(busy_out) && !$past(
      maskable_return_op_in || nonmaskable_return_op_in) |-> busy_out[*8]
      ##1 !busy_out) else $error("acceptance length wrong");
   a_start_at_end: assert property ($rose(busy_out) |-> $past(instr_last_in
      || maskable_return_op_in || nonmaskable_return_op_in))
      else $error("sequence began mid instruction");
   a_push_order_down: assert property (stack_out.we && $past(stack_out.we)
      |-> stack_out.addr == $past(stack_out.addr) - 8'h01)
      else $error("push address not descending");
   a_push_pc_high: assert property (stack_out.we && $past(stack_out.we)
      && !$past(stack_out.we, 2) |-> stack_out.data == pc_in[15:8])
      else $error("second push not pc high");
   a_push_pc_low: assert property (stack_out.we && $past(stack_out.we, 2)
      |-> stack_out.data == pc_in[7:0])
      else $error("third push not pc low");
   a_three_pushes: assert property ($rose(stack_out.we) |-> stack_out.we[*3]
      ##1 !stack_out.we) else $error("push count not three");
   a_load_single: assert property (pc_load_out |=> !pc_load_out)
      else $error("pc load longer than a cycle");
   a_load_follows: assert property ($rose(busy_out) |-> ##[1:10]
      pc_load_out) else $error("no pc load after sequence");
   a_ram_fetch_trap: assert property (fetch_in && fetch_ram_in |-> ##[1:2]
      trap_reset_out) else $error("ram fetch gave no reset");
   // main scenarios seen
   c_accept: cover property ($rose(busy_out));
   c_trap: cover property (trap_reset_out);
   c_ret_then_accept: cover property (maskable_return_op_in ##[1:20]
      $rose(busy_out));
endmodule : mis_seq_chk

bind mis_sequencer mis_seq_chk u_chk (.clk_in, .rst_n_in, .ce_in,
   .wb_cyc_in, .wb_stb_in, .wb_ack_out, .instr_last_in, .fetch_in,
   .fetch_ram_in, .maskable_return_op_in, .nonmaskable_return_op_in,
   .pc_in, .busy_out, .pc_load_out, .stack_out, .trap_reset_out);

// ===== mis_core_model.sv
// core, stack memory and vector table facing the sequencer
`timescale 1ns/10ps
module mis_core_model
   import mis_pkg::*;
#(
   parameter int LEN = 4                // cycles per modelled instruction
) (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                busy_in,     // core stalled
   input  wire logic                pc_load_in,
   input  wire logic [15:0]         pc_new_in,
   input  wire mis_pkg::mis_stack_t stack_in,
   input  wire logic [7:0]          vec_adr_in,
   output logic                     instr_last_out,
   output logic [15:0]              pc_out,
   output logic [7:0]               stack_rd_out,
   output logic [7:0]               vec_rd_out
);
   logic [7:0] mem [256];               // stack memory
   logic [7:0] cnt;                     // cycle within instruction
   ////////////////////////////////////////////////////////////////////////
   // last cycle marked only while the core runs
   assign instr_last_out = (cnt == 8'(LEN - 1)) && !busy_in;
   // instruction stepping, stack memory, scrambled vector table; the
   // bench may also patch the stack, as a trap handler would
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt <= 8'h00;
         pc_out <= 16'h1230;
      end else begin
         if (!busy_in) cnt <= instr_last_out ? 8'h00 : cnt + 8'h01;
         if (pc_load_in) pc_out <= pc_new_in;
         else if (instr_last_out) pc_out <= pc_out + 16'h0001;
      end
      if (stack_in.we) mem[stack_in.addr] <= stack_in.data;
      stack_rd_out <= mem[stack_in.addr];
      vec_rd_out <= vec_adr_in ^ 8'hA5;
   end
endmodule : mis_core_model

// ===== mis_sequencer_test.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
module mis_sequencer_test;
   import mis_pkg::*;
   logic clk_in, rst_n_in, cyc, stb, we, ack, busy, ld, trp, last;
   logic fetch, fabs, fram, maskable_return_op, nonmaskable_return_op;
   logic [7:0] adr, fdat, srd, vrd, vad, rnd, lv;
   logic [31:0] wdat, rdat, q;
   logic [15:0] src, pc, npc, pc0;
   logic [3:0] shr;                     // four, tx, five, converter
   mis_stack_t stk;
   logic [7:0] pd[$], pa[$];            // pushed data and addresses
   logic [15:0] lq[$];                  // pc loads seen
   int n_fail, check_count, i, n;
   ////////////////////////////////////////////////////////////////////////
   mis_sequencer DUT (.clk_in, .rst_n_in, .ce_in(1'b1), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .src_req_in(src), .ext_request_four_in(shr[0]),
      .serial_tx_request_in(shr[1]), .ext_request_five_in(shr[2]),
      .converter_done_request_in(shr[3]), .instr_last_in(last),
      .fetch_in(fetch), .fetch_data_in(fdat), .fetch_absent_in(fabs),
      .fetch_ram_in(fram), .maskable_return_op_in(maskable_return_op),
      .nonmaskable_return_op_in(nonmaskable_return_op), .pc_in(pc), .stack_rd_in(srd),
      .vec_rd_in(vrd), .busy_out(busy), .pc_load_out(ld), .pc_out(npc),
      .stack_out(stk), .vec_adr_out(vad), .trap_reset_out(trp));
   mis_core_model #(.LEN(4)) u_core (.clk_in, .rst_n_in, .busy_in(busy),
      .pc_load_in(ld), .pc_new_in(npc), .stack_in(stk), .vec_adr_in(vad),
      .instr_last_out(last), .pc_out(pc), .stack_rd_out(srd),
      .vec_rd_out(vrd));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   // record pushes and pc loads
   always @(posedge clk_in) begin
      if (stk.we === 1'b1) begin
         pd.push_back(stk.data);
         pa.push_back(stk.addr);
      end
      if (ld === 1'b1) lq.push_back(npc);
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // entry address from the scrambled vector table pair
   function automatic logic [15:0] vec(input logic [7:0] a);
      return {(a + 8'h01) ^ 8'hA5, a ^ 8'hA5};
   endfunction : vec
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_in);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (k >= 50) n_fail++;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic pulse_shr(input int k);
      @(posedge clk_in) shr <= 4'h1 << k;
      @(posedge clk_in) shr <= 4'h0;
   endtask : pulse_shr
   // wait until k pc loads have landed and the sequencer is idle
   task automatic wait_ld(input int k);
      for (n = 0; n < 200 && (lq.size() < k || busy !== 1'b0); n++)
         @(negedge clk_in);
      repeat (2) @(posedge clk_in);
      chk(lq.size(), k);
   endtask : wait_ld
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, maskable_return_op, nonmaskable_return_op, fetch, fabs, fram} = '0;
      {adr, fdat, wdat, src, shr} = '0;
      rnd = 8'h06;
      rst_n_in = 1'b0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(ADDR_ENABLE, {16'h0, RST_ENABLE});
      rd(ADDR_SELECT, {24'h0, RST_SELECT});
      rd(ADDR_LATCH, {16'h0, RST_LATCH});
      rd(ADDR_STACKP, {24'h0, RST_SP});
      rd(8'h20, 32'h0);
      bus(1'b1, ADDR_ENABLE, 32'h1);
      rd(ADDR_ENABLE, 32'h1);
      bus(1'b1, ADDR_ENABLE, 32'h0);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, ADDR_SELECT, 32'(i % 2) << (i / 2));
         pulse_shr(2 * (i / 2) + 1 - i % 2);
         rd(ADDR_LATCH, 32'h0);
         pulse_shr(2 * (i / 2) + i % 2);
         repeat (5) @(posedge clk_in);
         rd(ADDR_LATCH, 32'h1 << (LVL_15 + i / 2));
         bus(1'b1, ADDR_LATCH, 32'h0);
         rd(ADDR_LATCH, 32'h0);
      end
      bus(1'b1, ADDR_SELECT, 32'h0);
      rnd = lfsr(rnd);
      lv = 8'h04 + rnd % 8'h09;
      bus(1'b1, ADDR_ENABLE, 32'h3 << lv);
      @(posedge clk_in) src <= 16'h3 << lv;
      @(posedge clk_in) src <= 16'h0;
      repeat (40) @(posedge clk_in);
      chk(lq.size(), 0);
      bus(1'b1, ADDR_ENABLE, (32'h3 << lv) | 32'h1);
      for (n = 0; n < 60 && busy !== 1'b1; n++) @(negedge clk_in);
      pc0 = pc;
      chk(32'(n <= MAX_LAT_CYC), 32'h1);
      wait_ld(1);
      chk(lq[0], vec(8'hFC - 8'h02 * (lv + 8'h01)));
      chk({pd[0], pd[1], pd[2]}, {RST_PSW | 8'h01, pc0});
      chk({pa[1], pa[2]}, {RST_SP - 8'h01, RST_SP - 8'h02});
      rd(ADDR_STACKP, RST_SP - 8'h03);
      rd(ADDR_ENABLE, 32'h3 << lv);
      rd(ADDR_LATCH, 32'h1 << lv);
      rd(ADDR_STATUS, 32'(lv) + 32'h1);
      @(posedge clk_in) maskable_return_op <= 1'b1;
      @(posedge clk_in) maskable_return_op <= 1'b0;
      for (n = 0; n < 60 && lq.size() < 3; n++) @(negedge clk_in);
      chk(32'(n <= 24), 32'h1);
      wait_ld(3);
      chk(lq[1], pc0);
      chk(lq[2], vec(8'hFC - 8'h02 * lv));
      chk(pd[3], RST_PSW | 8'h01);
      rd(ADDR_STACKP, RST_SP - 8'h03);
      rd(ADDR_PSW, {24'h0, RST_PSW | 8'h01});
      for (i = 0; i < 2; i++) begin
         @(posedge clk_in);
         {fetch, fabs, fdat} <= {1'b1, i[0], i ? 8'h00 : OP_SOFT_TRAP};
         @(posedge clk_in) {fetch, fabs} <= 2'b00;
         wait_ld(4 + 2 * i);
         chk(lq[3 + 2 * i], vec(VEC_SOFT));
         // handler patches the stacked pc low byte on the absent fetch
         if (i == 1) u_core.mem[RST_SP - 8'h05] <= 8'h40;
         @(posedge clk_in) nonmaskable_return_op <= 1'b1;
         @(posedge clk_in) nonmaskable_return_op <= 1'b0;
         wait_ld(5 + 2 * i);
         chk(lq[4 + 2 * i],
             {pd[7 + 3 * i], i ? 8'h40 : pd[8 + 3 * i]});
      end
      @(posedge clk_in) {fetch, fram} <= 2'b11;
      @(posedge clk_in) {fetch, fram} <= 2'b00;
      for (n = 0; n < 4 && trp !== 1'b1; n++) @(negedge clk_in);
      chk(trp, 1'b1);
      wait_ld(7);
      stop_test();
   end
endmodule : mis_sequencer_test
